// ---- include/ascp_pkg.sv ----
// Constants and types shared by the ASCII system command parser files
package ascp_pkg;
  // Frame characters
  localparam logic [7:0] ASCP_CHAR_CR = 8'h0d; // Frame terminator
  localparam logic [7:0] ASCP_CHAR_DOLLAR = 8'h24; // Read command delimiter
  localparam logic [7:0] ASCP_CHAR_HASH = 8'h23; // Write command delimiter
  localparam logic [7:0] ASCP_CHAR_BANG = 8'h21; // Valid reply delimiter
  localparam logic [7:0] ASCP_CHAR_QUEST = 8'h3f; // Invalid reply delimiter
  localparam logic [7:0] ASCP_CHAR_GT = 8'h3e; // Flag reply delimiter
  localparam logic [7:0] ASCP_CHAR_M = 8'h4d; // Read name code
  localparam logic [7:0] ASCP_CHAR_F = 8'h46; // Read version code
  localparam logic [7:0] ASCP_CHAR_SEVEN = 8'h37; // Output diagnostic code
  localparam logic [7:0] ASCP_CHAR_V = 8'h56; // Flag access code, first char
  localparam logic [7:0] ASCP_CHAR_D = 8'h44; // Flag access code, second char
  localparam logic [6:0] ASCP_DIGIT_BASE = 7'h18; // Upper bits of ASCII 0 and 1
  // Station identity
  localparam logic [7:0] ASCP_OWN_ADDR = 8'h01; // Fixed station address
  localparam logic [7:0] ASCP_FAMILY_HI = 8'h35; // Arbitrary family prefix, first char
  localparam logic [7:0] ASCP_FAMILY_LO = 8'h41; // Arbitrary family prefix, second char
  localparam logic [7:0] ASCP_MODEL = 8'h2a; // Arbitrary model number
  localparam logic [31:0] ASCP_VERSION_TXT = 32'h302e3130; // Arbitrary version text
  // Character positions inside a command frame
  localparam logic [4:0] ASCP_POS_ADDR_HI = 5'h01;
  localparam logic [4:0] ASCP_POS_ADDR_LO = 5'h02;
  localparam logic [4:0] ASCP_POS_CODE_A = 5'h03;
  localparam logic [4:0] ASCP_POS_CODE_B = 5'h04;
  localparam logic [4:0] ASCP_POS_SEL_FIRST = 5'h05;
  localparam logic [4:0] ASCP_POS_SEL_LAST = 5'h08;
  localparam logic [4:0] ASCP_POS_VAL_FIRST = 5'h09;
  localparam logic [4:0] ASCP_POS_VAL_LAST = 5'h10;
  localparam logic [4:0] ASCP_POS_MAX = 5'h11; // Longest frame, CR position
  // Command lengths before the terminator
  localparam logic [4:0] ASCP_LEN_SHORT = 5'h04;
  localparam logic [4:0] ASCP_LEN_FREAD = 5'h05;
  localparam logic [4:0] ASCP_LEN_FWRITE = 5'h11;
  // Reply lengths including the terminator
  localparam logic [3:0] ASCP_RLEN_NAME = 4'h8;
  localparam logic [3:0] ASCP_RLEN_VER = 4'h8;
  localparam logic [3:0] ASCP_RLEN_SHORT = 4'h4;
  localparam logic [3:0] ASCP_RLEN_FLAGS = 4'hc;
  localparam logic [3:0] ASCP_RLEN_DIAG = 4'ha;
  localparam logic [3:0] ASCP_RIDX_BODY = 4'h3; // First body char of a reply
  // Widths and reset values
  localparam int ASCP_FLAG_W = 16;
  localparam int ASCP_DIAG_W = 6;
  localparam logic [15:0] ASCP_FLAGS_RST = 16'h0000;
  // Parser states and reply kinds
  typedef enum logic [1:0] {ASCP_ST_IDLE, ASCP_ST_RECV, ASCP_ST_SEND} ascp_state_t;
  typedef enum logic [2:0] {ASCP_RK_NAME, ASCP_RK_VER, ASCP_RK_ACK, ASCP_RK_FLAGS, ASCP_RK_DIAG,
                            ASCP_RK_NAK} ascp_rsp_t;
endpackage : ascp_pkg

// ---- logic/ascp_hex_dec.sv ----
// Uppercase ASCII hex character to nibble decoder
`timescale 1ns/1ns
module ascp_hex_dec (
  input wire logic [7:0] char_in, // Received character
  output logic [3:0] nib_out, // Decoded value
  output logic ok_out // High when char is 0-9 or A-F
);
  // Lowercase letters are refused on purpose
  always_comb begin
    nib_out = 4'h0;
    ok_out = 1'b0;
    if (char_in >= 8'h30 && char_in <= 8'h39) begin
      nib_out = char_in[3:0];
      ok_out = 1'b1;
    end else if (char_in >= 8'h41 && char_in <= 8'h46) begin
      nib_out = char_in[3:0] + 4'h9;
      ok_out = 1'b1;
    end
  end
endmodule : ascp_hex_dec

// ---- logic/ascp_hex_enc.sv ----
// Nibble to uppercase ASCII hex character encoder
`timescale 1ns/1ns
module ascp_hex_enc (
  input wire logic [3:0] nib_in, // Value to print
  output logic [7:0] char_out // Uppercase hex character
);
  // Letters start at A, digits at 0
  always_comb begin
    if (nib_in < 4'ha) begin
      char_out = 8'h30 + {4'h0, nib_in};
    end else begin
      char_out = 8'h37 + {4'h0, nib_in};
    end
  end
endmodule : ascp_hex_enc

// ---- logic/ascp_parser.sv ----
// ASCII system command parser: frame receiver, flag store and reply sender
`timescale 1ns/1ns
module ascp_parser
  import ascp_pkg::*;
(
  input wire logic clk_in, // 250 MHz system clock
  input wire logic rst_in, // Synchronous reset, active high
  input wire logic [7:0] rx_data_in, // Command byte from the link
  input wire logic rx_valid_in, // Command byte present
  input wire logic rx_err_in, // Link error on this byte
  output logic rx_ready_out, // Parser takes a byte
  output logic [7:0] tx_data_out, // Reply byte
  output logic tx_valid_out, // Reply byte present
  input wire logic tx_ready_in, // Link takes the reply byte
  input wire logic [5:0] diag_in, // Output fault pins, high is abnormal
  output logic [15:0] flags_out // Auxiliary logic flags
);
  // Parser state
  ascp_state_t state_reg, state_next;
  logic [7:0] dlm_reg, dlm_next; // Opening delimiter
  logic [4:0] pos_reg, pos_next; // Position of the next byte
  logic [7:0] addr_reg, addr_next; // Station address field
  logic [7:0] code_a_reg, code_a_next; // First command char
  logic [7:0] code_b_reg, code_b_next; // Second command char
  logic [15:0] sel_reg, sel_next; // Flag selector field
  logic [31:0] val_reg, val_next; // Flag value field
  logic syn_bad_reg, syn_bad_next; // Syntax error in address or length
  logic hex_bad_reg, hex_bad_next; // Non-hex char in selector or value
  logic drop_reg, drop_next; // Link error seen in this frame
  logic [15:0] flags_reg, flags_next; // Flag store
  // Reply state
  ascp_rsp_t kind_reg, kind_next;
  logic [3:0] idx_reg, idx_next; // Index of the next reply char
  logic [7:0] tx_data_reg, tx_data_next;
  logic tx_valid_reg, tx_valid_next;
  // Diagnostic pin synchroniser
  logic [5:0] diag_s1_reg, diag_s2_reg, diag_s3_reg;
  logic [5:0] diag_stable_reg, diag_stable_next;

  // Decoded incoming character
  logic [3:0] rx_nib;
  logic rx_hex;
  ascp_hex_dec ascp_hex_dec_i (
    .char_in(rx_data_in),
    .nib_out(rx_nib),
    .ok_out(rx_hex)
  );

  // Nibble to print and its character
  logic [3:0] enc_nib;
  logic [7:0] enc_char;
  ascp_hex_enc ascp_hex_enc_i (
    .nib_in(enc_nib),
    .char_out(enc_char)
  );

  // Handshake terms; no new command while a reply is queued
  logic rx_take;
  logic tx_load;
  assign rx_ready_out = (state_reg != ASCP_ST_SEND);
  assign rx_take = rx_valid_in && rx_ready_out;
  assign tx_load = (state_reg == ASCP_ST_SEND) && (!tx_valid_reg || tx_ready_in);
  assign tx_data_out = tx_data_reg;
  assign tx_valid_out = tx_valid_reg;
  assign flags_out = flags_reg;

  // Command classification, looked at when the terminator arrives
  logic cr_seen, frame_ok, sel_all, sel_one;
  logic is_name, is_ver, is_diag, is_fread, is_fwrite, code_vd;
  always_comb begin
    cr_seen = rx_take && (state_reg == ASCP_ST_RECV) && (rx_data_in == ASCP_CHAR_CR);
    // Short frames, bad address chars, link errors (the terminator's too) and other stations stay silent
    frame_ok = !drop_reg && !rx_err_in && !syn_bad_reg && (pos_reg >= ASCP_POS_CODE_A)
               && (addr_reg == ASCP_OWN_ADDR);
    code_vd = (code_a_reg == ASCP_CHAR_V) && (code_b_reg == ASCP_CHAR_D);
    sel_all = (sel_reg == 16'h0000);
    sel_one = (sel_reg[15:12] == 4'h1) && (sel_reg[11:4] == 8'h00);
    is_name = (dlm_reg == ASCP_CHAR_DOLLAR) && (pos_reg == ASCP_LEN_SHORT) && (code_a_reg == ASCP_CHAR_M);
    is_ver = (dlm_reg == ASCP_CHAR_DOLLAR) && (pos_reg == ASCP_LEN_SHORT) && (code_a_reg == ASCP_CHAR_F);
    is_diag = (dlm_reg == ASCP_CHAR_DOLLAR) && (pos_reg == ASCP_LEN_SHORT)
              && (code_a_reg == ASCP_CHAR_SEVEN);
    is_fread = (dlm_reg == ASCP_CHAR_DOLLAR) && (pos_reg == ASCP_LEN_FREAD) && code_vd;
    is_fwrite = (dlm_reg == ASCP_CHAR_HASH) && (pos_reg == ASCP_LEN_FWRITE) && code_vd && !hex_bad_reg
                && (sel_all || sel_one);
  end

  // Reply length and next reply character
  logic [3:0] rsp_len;
  logic [7:0] rsp_char;
  logic [2:0] body_k;
  logic [31:0] rd_word;
  always_comb begin
    body_k = 3'(idx_reg - ASCP_RIDX_BODY);
    rd_word = {16'h0000, flags_reg};
    enc_nib = 4'h0;
    case (kind_reg)
      ASCP_RK_NAME: rsp_len = ASCP_RLEN_NAME;
      ASCP_RK_VER: rsp_len = ASCP_RLEN_VER;
      ASCP_RK_FLAGS: rsp_len = ASCP_RLEN_FLAGS;
      ASCP_RK_DIAG: rsp_len = ASCP_RLEN_DIAG;
      default: rsp_len = ASCP_RLEN_SHORT;
    endcase
    // Nibble feeding the shared encoder
    if (idx_reg == 4'h1) begin
      enc_nib = ASCP_OWN_ADDR[7:4];
    end else if (idx_reg == 4'h2) begin
      enc_nib = ASCP_OWN_ADDR[3:0];
    end else if (kind_reg == ASCP_RK_NAME) begin
      enc_nib = (idx_reg == 4'h5) ? ASCP_MODEL[7:4] : ASCP_MODEL[3:0];
    end else if (kind_reg == ASCP_RK_FLAGS) begin
      enc_nib = rd_word[(7 - body_k) * 4 +: 4];
    end
    // Character at this index
    if (idx_reg == 4'h0) begin
      case (kind_reg)
        ASCP_RK_NAK: rsp_char = ASCP_CHAR_QUEST;
        ASCP_RK_ACK, ASCP_RK_FLAGS: rsp_char = ASCP_CHAR_GT;
        default: rsp_char = ASCP_CHAR_BANG;
      endcase
    end else if (idx_reg < ASCP_RIDX_BODY) begin
      rsp_char = enc_char;
    end else if (idx_reg == rsp_len - 4'h1) begin
      rsp_char = ASCP_CHAR_CR;
    end else begin
      case (kind_reg)
        ASCP_RK_NAME: begin
          if (idx_reg == 4'h3) begin
            rsp_char = ASCP_FAMILY_HI;
          end else if (idx_reg == 4'h4) begin
            rsp_char = ASCP_FAMILY_LO;
          end else begin
            rsp_char = enc_char;
          end
        end
        ASCP_RK_VER: rsp_char = ASCP_VERSION_TXT[(3 - body_k) * 8 +: 8];
        ASCP_RK_DIAG: rsp_char = {ASCP_DIGIT_BASE, diag_stable_reg[body_k]};
        default: rsp_char = enc_char;
      endcase
    end
  end

  // Next values of parser, flag store and reply sender
  always_comb begin
    state_next = state_reg;
    dlm_next = dlm_reg;
    pos_next = pos_reg;
    addr_next = addr_reg;
    code_a_next = code_a_reg;
    code_b_next = code_b_reg;
    sel_next = sel_reg;
    val_next = val_reg;
    syn_bad_next = syn_bad_reg;
    hex_bad_next = hex_bad_reg;
    drop_next = drop_reg;
    flags_next = flags_reg;
    kind_next = kind_reg;
    idx_next = idx_reg;
    tx_data_next = tx_data_reg;
    tx_valid_next = tx_valid_reg && !tx_ready_in;
    case (state_reg)
      ASCP_ST_IDLE: begin
        // Bytes outside a frame are ignored until a delimiter
        if (rx_take && (rx_data_in == ASCP_CHAR_DOLLAR || rx_data_in == ASCP_CHAR_HASH)) begin
          state_next = ASCP_ST_RECV;
          dlm_next = rx_data_in;
          pos_next = ASCP_POS_ADDR_HI;
          addr_next = 8'h00;
          code_a_next = 8'h00;
          code_b_next = 8'h00;
          sel_next = 16'h0000;
          val_next = 32'h00000000;
          syn_bad_next = 1'b0;
          hex_bad_next = 1'b0;
          drop_next = rx_err_in;
        end
      end
      ASCP_ST_RECV: begin
        if (rx_take && rx_err_in) begin
          drop_next = 1'b1;
        end
        if (cr_seen) begin
          // End of frame: answer, refuse or stay silent
          state_next = frame_ok ? ASCP_ST_SEND : ASCP_ST_IDLE;
          idx_next = 4'h0;
          if (is_name) begin
            kind_next = ASCP_RK_NAME;
          end else if (is_ver) begin
            kind_next = ASCP_RK_VER;
          end else if (is_diag) begin
            kind_next = ASCP_RK_DIAG;
          end else if (is_fread) begin
            kind_next = ASCP_RK_FLAGS;
          end else if (is_fwrite) begin
            kind_next = ASCP_RK_ACK;
          end else begin
            kind_next = ASCP_RK_NAK;
          end
          if (frame_ok && is_fwrite) begin
            if (sel_all) begin
              flags_next = val_reg[15:0];
            end else begin
              flags_next[sel_reg[3:0]] = val_reg[0];
            end
          end
        end else if (rx_take) begin
          // Overlong frames are treated as syntax errors
          if (pos_reg == ASCP_POS_MAX) begin
            syn_bad_next = 1'b1;
          end else begin
            pos_next = pos_reg + 5'h01;
          end
          if (pos_reg == ASCP_POS_ADDR_HI || pos_reg == ASCP_POS_ADDR_LO) begin
            addr_next = {addr_reg[3:0], rx_nib};
            if (!rx_hex) begin
              syn_bad_next = 1'b1;
            end
          end else if (pos_reg == ASCP_POS_CODE_A) begin
            code_a_next = rx_data_in;
          end else if (pos_reg == ASCP_POS_CODE_B) begin
            code_b_next = rx_data_in;
          end else if (pos_reg >= ASCP_POS_SEL_FIRST && pos_reg <= ASCP_POS_SEL_LAST) begin
            sel_next = {sel_reg[11:0], rx_nib};
            hex_bad_next = hex_bad_reg || !rx_hex;
          end else if (pos_reg >= ASCP_POS_VAL_FIRST && pos_reg <= ASCP_POS_VAL_LAST) begin
            val_next = {val_reg[27:0], rx_nib};
            hex_bad_next = hex_bad_reg || !rx_hex;
          end
        end
      end
      ASCP_ST_SEND: begin
        // One char per accepted slot; the register holds it under back-pressure
        if (tx_load) begin
          tx_data_next = rsp_char;
          tx_valid_next = 1'b1;
          idx_next = idx_reg + 4'h1;
          if (idx_reg == rsp_len - 4'h1) begin
            state_next = ASCP_ST_IDLE;
          end
        end
      end
      default: state_next = ASCP_ST_IDLE;
    endcase
  end

  // Diagnostic level accepted once stages two and three agree
  always_comb begin
    diag_stable_next = (diag_s2_reg & diag_s3_reg) | (diag_stable_reg & (diag_s2_reg | diag_s3_reg));
  end

  // Register all state
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= ASCP_ST_IDLE;
      dlm_reg <= 8'h00;
      pos_reg <= 5'h00;
      addr_reg <= 8'h00;
      code_a_reg <= 8'h00;
      code_b_reg <= 8'h00;
      sel_reg <= 16'h0000;
      val_reg <= 32'h00000000;
      syn_bad_reg <= 1'b0;
      hex_bad_reg <= 1'b0;
      drop_reg <= 1'b0;
      flags_reg <= ASCP_FLAGS_RST;
      kind_reg <= ASCP_RK_NAK;
      idx_reg <= 4'h0;
      tx_data_reg <= 8'h00;
      tx_valid_reg <= 1'b0;
      diag_s1_reg <= 6'h00;
      diag_s2_reg <= 6'h00;
      diag_s3_reg <= 6'h00;
      diag_stable_reg <= 6'h00;
    end else begin
      state_reg <= state_next;
      dlm_reg <= dlm_next;
      pos_reg <= pos_next;
      addr_reg <= addr_next;
      code_a_reg <= code_a_next;
      code_b_reg <= code_b_next;
      sel_reg <= sel_next;
      val_reg <= val_next;
      syn_bad_reg <= syn_bad_next;
      hex_bad_reg <= hex_bad_next;
      drop_reg <= drop_next;
      flags_reg <= flags_next;
      kind_reg <= kind_next;
      idx_reg <= idx_next;
      tx_data_reg <= tx_data_next;
      tx_valid_reg <= tx_valid_next;
      diag_s1_reg <= diag_in;
      diag_s2_reg <= diag_s1_reg;
      diag_s3_reg <= diag_s2_reg;
      diag_stable_reg <= diag_stable_next;
    end
  end

  // Checks on frame decisions and reply bytes
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_cr_good;
    cr_seen && frame_ok;
  endsequence
  sequence s_last_load;
    tx_load && (idx_reg == rsp_len - 4'h1);
  endsequence
  a_nak_on_unknown: assert property (s_cr_good ##0 !(is_name || is_ver || is_diag || is_fread || is_fwrite)
    |=> state_reg == ASCP_ST_SEND && kind_reg == ASCP_RK_NAK) else $error("no refusal reply");
  a_silent_on_error: assert property (cr_seen && !frame_ok |=> state_reg == ASCP_ST_IDLE && !tx_load)
    else $error("reply to bad frame");
  a_name_reply_kind: assert property (s_cr_good ##0 is_name |=> kind_reg == ASCP_RK_NAME ##1 tx_valid_out
    && tx_data_out == ASCP_CHAR_BANG) else $error("name reply wrong");
  a_ver_reply_kind: assert property (s_cr_good ##0 is_ver |=> kind_reg == ASCP_RK_VER)
    else $error("version reply wrong");
  a_flag_all_write: assert property (s_cr_good ##0 is_fwrite && sel_all |=> flags_out == $past(val_reg[15:0]))
    else $error("bulk flag write wrong");
  a_flag_one_write: assert property (s_cr_good ##0 is_fwrite && sel_one |=>
    flags_out[$past(sel_reg[3:0])] == $past(val_reg[0])
    && ((flags_out ^ $past(flags_out)) & ~(16'h0001 << $past(sel_reg[3:0]))) == 16'h0000)
    else $error("single flag write wrong");
  a_write_ack_kind: assert property (s_cr_good ##0 is_fwrite |=> kind_reg == ASCP_RK_ACK ##1
    tx_data_out == ASCP_CHAR_GT) else $error("write ack wrong");
  a_reply_ends_cr: assert property (s_last_load |=> tx_valid_out && tx_data_out == ASCP_CHAR_CR
    && state_reg == ASCP_ST_IDLE) else $error("reply not ended by CR");
  a_diag_char: assert property (tx_load && kind_reg == ASCP_RK_DIAG && idx_reg >= 4'h3 && idx_reg <= 4'h8
    |=> tx_data_out[7:1] == ASCP_DIGIT_BASE) else $error("diag char not 0 or 1");
  a_tx_hold_data: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
    else $error("reply byte dropped");
endmodule : ascp_parser

// ---- tb/ascp_host_model.sv ----
// Remote host model: sends command frames and collects reply bytes
`timescale 1ns/1ns
module ascp_host_model
  import ascp_pkg::*;
(
  input wire logic clk_in, // System clock
  input wire logic slow_in, // Stall reply bytes on alternate cycles
  input wire logic rx_ready_in, // Parser takes a byte
  output logic [7:0] rx_data_out, // Command byte
  output logic rx_valid_out, // Command byte present
  output logic rx_err_out, // Link error on this byte
  input wire logic [7:0] tx_data_in, // Reply byte
  input wire logic tx_valid_in, // Reply byte present
  output logic tx_ready_out // Takes the reply byte
);
  logic [7:0] rsp_q[$]; // Reply bytes in arrival order
  logic stall_reg = 1'b0; // Alternating stall phase

  // Idle levels at time zero
  initial begin
    rx_data_out = 8'h00;
    rx_valid_out = 1'b0;
    rx_err_out = 1'b0;
  end

  // Stall phase flips just after each edge, never on it
  always @(posedge clk_in) begin
    #1;
    stall_reg = ~stall_reg;
  end
  assign tx_ready_out = !(slow_in && stall_reg);

  // Reply byte leaves at an edge with valid and ready both high
  always @(posedge clk_in) begin
    if (tx_valid_in === 1'b1 && tx_ready_out) begin
      rsp_q.push_back(tx_data_in);
    end
  end

  // Frame sender; caller enters just after an edge; bytes held until taken
  task automatic send_frame(input string cmd, input int err_at);
    int i;
    for (i = 0; i <= cmd.len(); i++) begin
      rx_data_out = (i == cmd.len()) ? ASCP_CHAR_CR : cmd[i];
      rx_err_out = (i == err_at);
      rx_valid_out = 1'b1;
      // Ready is combinational but settled once the edge's updates land
      while (rx_ready_in !== 1'b1) begin
        @(posedge clk_in);
        #1;
      end
      @(posedge clk_in);
      #1;
    end
    rx_valid_out = 1'b0;
    rx_err_out = 1'b0;
    // Released line shows the inverse, not a stale byte
    rx_data_out = ~rx_data_out;
  endtask : send_frame
endmodule : ascp_host_model

// ---- tb/ascp_parser_bench.sv ----
// Self-checking bench for the ASCII system command parser
`timescale 1ns/1ns
module ascp_parser_bench;
  import ascp_pkg::*;
  logic clk_in; // System clock
  logic rst_in; // Synchronous reset
  logic [7:0] rx_data; // Command byte
  logic rx_valid; // Command byte present
  logic rx_err; // Link error
  logic rx_ready_out; // Parser ready
  logic [7:0] tx_data_out; // Reply byte
  logic tx_valid_out; // Reply byte present
  logic tx_ready; // Sink ready
  logic [5:0] diag; // Output fault pins
  logic [15:0] flags_out; // Auxiliary flags
  logic slow; // Sink stalls when high
  int miscompares = 0; // Mismatch count
  int checked = 0; // Comparison count
  int cycles = 0; // Hang guard
  string nm; // Expected name reply

  ascp_parser ascp_parser_i (.clk_in(clk_in), .rst_in(rst_in), .rx_data_in(rx_data), .rx_valid_in(rx_valid),
    .rx_err_in(rx_err), .rx_ready_out(rx_ready_out), .tx_data_out(tx_data_out), .tx_valid_out(tx_valid_out),
    .tx_ready_in(tx_ready), .diag_in(diag), .flags_out(flags_out));
  ascp_host_model ascp_host_model_i (.clk_in(clk_in), .slow_in(slow), .rx_ready_in(rx_ready_out),
    .rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_err_out(rx_err), .tx_data_in(tx_data_out),
    .tx_valid_in(tx_valid_out), .tx_ready_out(tx_ready));

  // 250 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // Whole run needs under 1000 cycles; ceiling leaves wide margin
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  // Closing report and verdict
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  // Value compare, four-state exact
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val

  // Reply compare; empty text means the device must stay silent
  task automatic cmp_rsp(input string exp);
    int n;
    int i;
    logic [7:0] b;
    n = 0;
    if (exp.len() == 0) begin
      repeat (60) @(posedge clk_in);
      #1;
      cmp_val(16'(ascp_host_model_i.rsp_q.size()), 16'h0000);
    end else begin
      // Bounded wait for the whole reply plus terminator
      while (ascp_host_model_i.rsp_q.size() <= exp.len() && n < 200) begin
        @(posedge clk_in);
        #1;
        n++;
      end
      for (i = 0; i <= exp.len(); i++) begin
        b = (ascp_host_model_i.rsp_q.size() > 0) ? ascp_host_model_i.rsp_q.pop_front() : 8'hxx;
        cmp_val({8'h00, b}, {8'h00, (i == exp.len()) ? ASCP_CHAR_CR : 8'(exp[i])});
      end
    end
  endtask : cmp_rsp

  // Uppercase hex text of the low n digits, most significant first
  function automatic string hexs(input logic [15:0] v, input int n);
    string s;
    int i;
    logic [3:0] d;
    s = "";
    for (i = n - 1; i >= 0; i--) begin
      d = v[i*4 +: 4];
      s = $sformatf("%s%c", s, (d < 4'ha) ? 8'h30 + 8'(d) : 8'h37 + 8'(d));
    end
    return s;
  endfunction : hexs

  // One frame, its reply and the flag state afterwards
  task automatic run(input string cmd, input int err_at, input string exp, input logic [15:0] flg);
    ascp_host_model_i.send_frame(cmd, err_at);
    cmp_rsp(exp);
    cmp_val(flags_out, flg);
    $display("Test done: %s", cmd);
  endtask : run

  // Main sequence
  initial begin
    rst_in = 1'b1;
    diag = 6'h00;
    slow = 1'b0;
    nm = $sformatf("!01%c%c%s", ASCP_FAMILY_HI, ASCP_FAMILY_LO, hexs({8'h00, ASCP_MODEL}, 2));
    repeat (3) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    cmp_val({14'h0000, rx_ready_out, tx_valid_out}, 16'h0002);
    cmp_val(flags_out, ASCP_FLAGS_RST);
    // First byte only after the release edge has passed
    @(posedge clk_in);
    #1;
    run("$01M", -1, nm, 16'h0000);
    run("$01F", -1, $sformatf("!01%s", ASCP_VERSION_TXT), 16'h0000);
    run("#01VD0000ABCD12F5", -1, ">01", 16'h12f5);
    run("#01VD100300000001", -1, ">01", 16'h12fd);
    run("#01VD100C00000000", -1, ">01", 16'h02fd);
    run("#01VD100F00000001", -1, ">01", 16'h82fd);
    run("$01VD", -1, {">010000", hexs(16'h82fd, 4)}, 16'h82fd);
    run("#01VD00000000002B", -1, ">01", 16'h002b);
    run("$01VD", -1, ">010000002B", 16'h002b);
    // Refused forms from our own address get the question reply
    run("$01X", -1, "?01", 16'h002b);
    run("$01Vd", -1, "?01", 16'h002b);
    run("#01VD2000000000FF", -1, "?01", 16'h002b);
    // Silent cases must also leave the flags alone
    run("#02VD0000000000FF", -1, "", 16'h002b);
    run("#01VD0000000000FF", 6, "", 16'h002b);
    run("#01VD0000000000FF", 17, "", 16'h002b);
    run("$0G7", -1, "", 16'h002b);
    // Diagnostic chars in output order 0 to 5
    diag = 6'b011101;
    run("$017", -1, "!01101110", 16'h002b);
    diag = 6'b100010;
    run("$017", -1, "!01010001", 16'h002b);
    // Stalling sink; second frame is held while the first reply drains
    slow = 1'b1;
    ascp_host_model_i.send_frame("$01VD", -1);
    // One idle edge so valid is never dropped and raised in one step
    @(posedge clk_in);
    #1;
    ascp_host_model_i.send_frame("$01M", -1);
    cmp_rsp(">010000002B");
    cmp_rsp(nm);
    $display("Test done: stalled back-to-back");
    give_verdict();
  end
endmodule : ascp_parser_bench
